//--- inc/lsc_pkg.sv
package lsc_pkg;
    localparam logic [6:0] ADDR_STRAP_HIGH = 7'h67;
    localparam logic [6:0] ADDR_STRAP_LOW = 7'h18;
    localparam logic [7:0] REG_GENERAL = 8'h10;
    localparam logic [7:0] GEN_RESET = 8'h00;
    localparam int GEN_EXT_CLK_BIT = 6;
    localparam int GEN_DIM_EN_LSB = 3;
    localparam int GEN_OUT_EN_LSB = 0;
    localparam int SYNC_DIVIDE = 32;
    localparam int NUM_SINKS = 3;
    localparam int BYTE_BITS = 8;

    typedef struct packed {
        logic scl;
        logic sda;
    } lsc_bus_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } lsc_wr_t;
endpackage

//--- rtl/lsc_sync_div.sv
`timescale 1ns/100ps
// divides the synchronised sync clock into one tick per 32 rising edges
module lsc_sync_div #(
    parameter int DIVIDE = lsc_pkg::SYNC_DIVIDE
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic sync_rise,
    input wire logic clear,
    output logic tick
);
    logic [$clog2(DIVIDE)-1:0] count;
    logic [$clog2(DIVIDE)-1:0] next_count;
    logic next_tick;

    always_comb begin
        next_count = count;
        next_tick = 1'b0;
        if (clear) begin
            next_count = '0;
        end else if (sync_rise) begin
            if (count == $clog2(DIVIDE)'(DIVIDE - 1)) begin
                next_count = '0;
                next_tick = 1'b1;
            end else begin
                next_count = count + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= '0;
            tick <= 1'b0;
        end else begin
            count <= next_count;
            tick <= next_tick;
        end
    end
endmodule

//--- rtl/lsc_top.sv
`timescale 1ns/100ps
// Functional notes
// - gain goes to 3/2 when any enabled sink falls near threshold; disabled ignored
// - enable pin low holds registers at default and outputs disabled
// - timing base comes from sync input only when external-clock bit set
// - external sync clock divided by thirty-two for pwm and step base
// - target address 0x67 with strap high, 0x18 with strap low
// - data falling while clock high is a start
// - data rising while clock high is a stop
// - bus busy from start until the following stop
// - repeated start behaves like a first start
// - data driver changes data only while clock low
// - bytes are eight bits, most significant first
// - device pulls data low for the whole ninth pulse
// - first byte is seven-bit address then direction bit, zero write
// - second byte selects register, third byte is the data
// - external-clock bit one picks sync, zero picks internal
module lsc_top #(
    parameter int SYNC_DIVIDE = lsc_pkg::SYNC_DIVIDE
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic addr_strap,
    input wire logic hardware_enable_reset_pin,
    input wire logic sync_in,
    input wire logic int_tick,
    input wire logic [2:0] led_sink_low,
    output logic [7:0] general_ctrl,
    output logic [2:0] led_sink_output,
    output logic time_tick,
    output logic gain_three_half,
    output logic bus_busy,
    output logic [15:0] reg_write,
    output logic reg_write_valid
);
    ////////////////////////////////////////////////////////////////
    // input synchronisers; first stage is read only by second stage
    logic [3:0] meta;
    logic [3:0] stable;
    lsc_pkg::lsc_bus_t bus;
    lsc_pkg::lsc_bus_t bus_q;
    logic en_q;
    logic sync_q;
    logic [2:0] low_q;
    logic [2:0] low_meta;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            // sync resets low like its idle pin, so no false edge after reset
            meta <= 4'he;
            stable <= 4'he;
            low_meta <= 3'h0;
            low_q <= 3'h0;
        end else begin
            meta <= {scl_in, sda_in, hardware_enable_reset_pin, sync_in};
            stable <= meta;
            low_meta <= led_sink_low;
            low_q <= low_meta;
        end
    end

    assign bus.scl = stable[3];
    assign bus.sda = stable[2];
    assign en_q = stable[1];
    assign sync_q = stable[0];

    // soft reset: synchronised enable pin low only; async rst is handled on its own
    logic off;
    assign off = !en_q;

    ////////////////////////////////////////////////////////////////
    // edge and condition detection
    logic sync_prev;
    logic start_seen;
    logic stop_seen;
    logic scl_rise;
    logic scl_fall;
    assign start_seen = bus_q.scl && bus.scl && bus_q.sda && !bus.sda;
    assign stop_seen = bus_q.scl && bus.scl && !bus_q.sda && bus.sda;
    assign scl_rise = !bus_q.scl && bus.scl;
    assign scl_fall = bus_q.scl && !bus.scl;

    ////////////////////////////////////////////////////////////////
    // byte receiver state machine
    typedef enum logic [2:0] {
        LSC_IDLE,
        LSC_ADDR,
        LSC_REG,
        LSC_DATA,
        LSC_IGNORE
    } lsc_state_t;

    lsc_state_t state;
    lsc_state_t next_state;
    logic [3:0] bit_cnt;
    logic [3:0] next_bit_cnt;
    logic [7:0] shreg;
    logic [7:0] next_shreg;
    logic [7:0] reg_sel;
    logic [7:0] next_reg_sel;
    logic ack;
    logic next_ack;
    logic next_busy;
    logic [7:0] next_gen;
    logic next_valid;
    logic [15:0] next_write;
    logic [6:0] my_addr;

    ////////////////////////////////////////////////////////////////
    // strap is a pin too, so it gets two flops like the bus
    logic addr_strap_meta;
    logic addr_strap_q;
    assign my_addr = addr_strap_q ? lsc_pkg::ADDR_STRAP_HIGH : lsc_pkg::ADDR_STRAP_LOW;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            addr_strap_meta <= 1'b0;
            addr_strap_q <= 1'b0;
        end else begin
            addr_strap_meta <= addr_strap;
            addr_strap_q <= addr_strap_meta;
        end
    end

    // read direction is never accepted
    function automatic logic lsc_addr_ok(input logic [7:0] first, input logic [6:0] own);
        return (first[7:1] == own) && !first[0];
    endfunction

    always_comb begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_shreg = shreg;
        next_reg_sel = reg_sel;
        next_ack = ack;
        next_busy = bus_busy;
        next_gen = general_ctrl;
        next_valid = 1'b0;
        next_write = reg_write;
        if (start_seen) begin
            next_busy = 1'b1;
            next_state = LSC_ADDR;
            next_bit_cnt = 4'h0;
            next_ack = 1'b0;
        end else if (stop_seen) begin
            next_busy = 1'b0;
            next_state = LSC_IDLE;
            next_ack = 1'b0;
        end else if (state != LSC_IDLE && state != LSC_IGNORE) begin
            if (scl_rise && bit_cnt < 4'(lsc_pkg::BYTE_BITS)) begin
                next_shreg = {shreg[6:0], bus.sda};
                next_bit_cnt = bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == 4'(lsc_pkg::BYTE_BITS) && !ack) begin
                // change only while clock low
                case (state)
                    LSC_ADDR: begin
                        // read direction is not supported, so it is not acknowledged
                        if (lsc_addr_ok(shreg, my_addr)) begin
                            next_ack = 1'b1;
                        end else begin
                            next_state = LSC_IGNORE;
                        end
                    end
                    default: next_ack = 1'b1;
                endcase
            end else if (scl_fall && ack) begin
                next_ack = 1'b0;
                next_bit_cnt = 4'h0;
                case (state)
                    LSC_ADDR: next_state = LSC_REG;
                    LSC_REG: begin
                        next_reg_sel = shreg;
                        next_state = LSC_DATA;
                    end
                    LSC_DATA: begin
                        next_valid = 1'b1;
                        next_write = {reg_sel, shreg};
                        if (reg_sel == lsc_pkg::REG_GENERAL) begin
                            next_gen = shreg;
                        end
                        next_state = LSC_IGNORE;
                    end
                    default: next_state = LSC_IGNORE;
                endcase
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bus_q <= '1;
            sync_prev <= 1'b0;
            state <= LSC_IDLE;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            reg_sel <= 8'h00;
            ack <= 1'b0;
            bus_busy <= 1'b0;
            general_ctrl <= lsc_pkg::GEN_RESET;
            reg_write_valid <= 1'b0;
            reg_write <= 16'h0000;
        end else if (off) begin
            bus_q <= bus;
            sync_prev <= sync_q;
            state <= LSC_IDLE;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            reg_sel <= 8'h00;
            ack <= 1'b0;
            bus_busy <= 1'b0;
            general_ctrl <= lsc_pkg::GEN_RESET;
            reg_write_valid <= 1'b0;
            reg_write <= 16'h0000;
        end else begin
            bus_q <= bus;
            sync_prev <= sync_q;
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            shreg <= next_shreg;
            reg_sel <= next_reg_sel;
            ack <= next_ack;
            bus_busy <= next_busy;
            general_ctrl <= next_gen;
            reg_write_valid <= next_valid;
            reg_write <= next_write;
        end
    end

    // open drain: only ever drive low
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sda_oe <= 1'b0;
            sda_out <= 1'b0;
        end else begin
            sda_oe <= next_ack && !off;
            sda_out <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // time base and gain
    logic ext_sel;
    logic ext_tick;
    assign ext_sel = general_ctrl[lsc_pkg::GEN_EXT_CLK_BIT];

    lsc_sync_div #(
        .DIVIDE(SYNC_DIVIDE)
    ) u_div (
        .clk(clk),
        .rst(rst),
        .sync_rise(sync_q && !sync_prev),
        .clear(off || !ext_sel),
        .tick(ext_tick)
    );

    logic [2:0] enabled;
    assign enabled = general_ctrl[lsc_pkg::GEN_OUT_EN_LSB +: lsc_pkg::NUM_SINKS]
        | general_ctrl[lsc_pkg::GEN_DIM_EN_LSB +: lsc_pkg::NUM_SINKS];

    // a disabled sink never votes for the higher gain
    logic [2:0] sink_hit;
    for (genvar i = 0; i < lsc_pkg::NUM_SINKS; i++) begin : g_sink
        assign sink_hit[i] = low_q[i] && enabled[i];
    end

    // internal tick is an input from same-domain oscillator logic
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            time_tick <= 1'b0;
            gain_three_half <= 1'b0;
            led_sink_output <= 3'h0;
        end else begin
            time_tick <= ext_sel ? ext_tick : int_tick;
            // gain only ever resets by enable pin or async rst, like a latched comparator
            gain_three_half <= off ? 1'b0 : (gain_three_half || |sink_hit);
            led_sink_output <= off ? 3'h0 : enabled;
        end
    end
endmodule

//--- tb/lsc_i2c_master.sv
`timescale 1ns/100ps
// bus master model; data only ever pulled low, pull-up does the rest
module lsc_i2c_master (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    ////////////////////////////////////////
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // clock high phase of 10 cycles, well above the sync delay of the target
    task automatic ph(input logic c, input logic rel, input int n);
        scl = c;
        sda_low = !rel;
        wt(n);
    endtask
    task automatic start();
        ph(0, 1, 4);
        ph(1, 1, 10);
        ph(1, 0, 10);
        ph(0, 0, 4);
    endtask
    task automatic stop();
        ph(0, 0, 6);
        ph(1, 0, 10);
        ph(1, 1, 10);
    endtask
    task automatic send(input logic [7:0] b, input int n, output logic ack);
        for (int i = 7; i > 7 - n; i--) begin
            ph(0, b[i], 6);
            ph(1, b[i], 10);
            ph(0, b[i], 4);
        end
        ack = 1'b0;
        if (n == 8) begin
            ph(0, 1, 6);
            ph(1, 1, 5);
            ack = !sda;
            ph(1, 1, 5);
            ph(0, 1, 4);
        end
    endtask
endmodule

//--- tb/lsc_monitor.sv
`timescale 1ns/100ps
module lsc_monitor #(
    parameter int SYNC_DIVIDE = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic addr_strap,
    input wire logic hardware_enable_reset_pin,
    input wire logic sync_in,
    input wire logic int_tick,
    input wire logic [2:0] led_sink_low,
    input wire logic [7:0] general_ctrl,
    input wire logic [2:0] led_sink_output,
    input wire logic time_tick,
    input wire logic gain_three_half,
    input wire logic bus_busy,
    input wire logic [15:0] reg_write,
    input wire logic reg_write_valid
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////
    a_out_low: assert property (!sda_out) else $error("data driven high");
    a_oe_scl_low: assert property ($rose(sda_oe) |-> !scl_in) else $error("ack began in clock high");
    a_oe_held: assert property (sda_oe && scl_in |=> sda_oe) else $error("ack dropped in clock high");
    a_valid_pulse: assert property (reg_write_valid |=> !reg_write_valid) else $error("long write pulse");
    a_busy_start: assert property ($fell(sda_in) && scl_in |-> ##[1:6] bus_busy) else $error("start missed");
    a_busy_stop: assert property ($rose(sda_in) && scl_in |-> ##[1:6] !bus_busy) else $error("stop missed");
    // two quiet cycles so the registered outputs have caught up
    a_led_map: assert property ($stable(general_ctrl) ##1 $stable(general_ctrl)
        |-> led_sink_output == (general_ctrl[2:0] | general_ctrl[5:3])) else $error("sink enable wrong");
    a_gain_on: assert property (((led_sink_low & led_sink_output) != 3'h0)[*6] |=> gain_three_half)
        else $error("gain not raised");
    a_tick_int: assert property (!general_ctrl[6] && !$past(general_ctrl[6]) && !$past(rst)
        |-> time_tick == $past(int_tick)) else $error("internal tick wrong");
    c_write: cover property (reg_write_valid);
    c_gain: cover property ($rose(gain_three_half));
    c_ext: cover property (general_ctrl[6] && time_tick);
endmodule
bind lsc_top lsc_monitor #(.SYNC_DIVIDE(SYNC_DIVIDE)) u_mon (.clk(clk), .rst(rst), .scl_in(scl_in),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap(addr_strap),
    .hardware_enable_reset_pin(hardware_enable_reset_pin), .sync_in(sync_in), .int_tick(int_tick),
    .led_sink_low(led_sink_low), .general_ctrl(general_ctrl), .led_sink_output(led_sink_output),
    .time_tick(time_tick), .gain_three_half(gain_three_half), .bus_busy(bus_busy),
    .reg_write(reg_write), .reg_write_valid(reg_write_valid));

//--- tb/lsc_top_tb_top.sv
`timescale 1ns/100ps
module lsc_top_tb_top;
    logic clk = 0;
    logic rst;
    logic addr_strap;
    logic hardware_enable_reset_pin;
    logic sync_in = 0;
    logic int_tick = 0;
    logic [2:0] led_sink_low;
    logic scl_in, m_low, sda_out, sda_oe, time_tick, gain_three_half, bus_busy, reg_write_valid, ack;
    logic [7:0] general_ctrl, egc;
    logic [2:0] led_sink_output;
    logic [15:0] reg_write, last_wr;
    logic [31:0] rs = 32'h689a;
    int n_errors = 0, samples_checked = 0, cyc = 0, n_wr = 0, tcyc = 0, gap = 0, sc = 0;
    wire sda_in = !(m_low || sda_oe);
    always #50 clk = ~clk;
    lsc_top #(.SYNC_DIVIDE(32)) dut (.clk(clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in),
        .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap(addr_strap),
        .hardware_enable_reset_pin(hardware_enable_reset_pin), .sync_in(sync_in), .int_tick(int_tick),
        .led_sink_low(led_sink_low), .general_ctrl(general_ctrl), .led_sink_output(led_sink_output),
        .time_tick(time_tick), .gain_three_half(gain_three_half), .bus_busy(bus_busy),
        .reg_write(reg_write), .reg_write_valid(reg_write_valid));
    lsc_i2c_master m (.clk(clk), .sda(sda_in), .scl(scl_in), .sda_low(m_low));
    ////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("TB: %0d checks, %0d errors", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // sync at 1 MHz, internal tick every 7 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        sc <= (sc == 4) ? 0 : sc + 1;
        int_tick <= #1 (cyc % 7 == 0);
        if (sc == 4) sync_in <= #1 !sync_in;
        if (reg_write_valid === 1'b1) begin
            n_wr <= n_wr + 1;
            last_wr <= reg_write;
        end
        if (time_tick === 1'b1) begin
            gap <= cyc - tcyc;
            tcyc <= cyc;
        end
        if (cyc == 30000) begin
            n_errors++;
            print_verdict();
        end
    end
    task automatic wr3(input logic [7:0] a, input logic [7:0] r, input logic [7:0] d, input logic ea);
        int w0;
        w0 = n_wr;
        m.start();
        m.send(a, 8, ack);
        chk(ack, ea);
        m.send(r, 8, ack);
        chk(ack, ea);
        m.send(d, 8, ack);
        chk(ack, ea);
        m.stop();
        m.wt(8);
        chk(bus_busy, 0);
        chk(n_wr - w0, ea);
        if (ea && r == 8'h10) egc = d;
        if (ea) chk(last_wr, {r, d});
        chk(general_ctrl, egc);
        chk(led_sink_output, egc[2:0] | egc[5:3]);
    endtask
    ////////////////////////////////////////
    initial begin
        int w1;
        rst = 1'b1;
        addr_strap = 1'b0;
        hardware_enable_reset_pin = 1'b0;
        led_sink_low = 3'h0;
        repeat (6) @(posedge clk);
        #1;
        rst = 0;
        hardware_enable_reset_pin = 1;
        m.wt(6);
        for (int s = 0; s < 2; s++) begin
            addr_strap = s[0];
            rst = 1;
            m.wt(2);
            rst = 0;
            m.wt(6);
            egc = 8'h00;
            chk(general_ctrl, 8'h00);
            for (int k = 0; k < 3; k++) begin
                rs = xs(rs);
                wr3({s ? 7'h67 : 7'h18, 1'b0}, 8'h10, rs[7:0] & 8'h3f, 1);
                wr3({s ? 7'h18 : 7'h67, 1'b0}, 8'h10, 8'h3f, 0);
                wr3({s ? 7'h67 : 7'h18, 1'b1}, 8'h10, 8'h3f, 0);
                wr3({s ? 7'h67 : 7'h18, 1'b0}, rs[15:8], rs[23:16], 1);
            end
            $display("TB: address test %0d done", s);
        end
        // data byte cut short, then a restart in mid-transaction
        w1 = n_wr;
        m.start();
        m.send(8'hce, 8, ack);
        m.send(8'h10, 8, ack);
        m.send(8'hff, 5, ack);
        m.stop();
        m.wt(8);
        chk(n_wr, w1);
        chk(general_ctrl, egc);
        m.start();
        m.send(8'hce, 8, ack);
        m.send(8'h10, 8, ack);
        wr3(8'hce, 8'h10, 8'h01, 1);
        $display("TB: abort test done");
        led_sink_low = 3'b110;
        m.wt(10);
        chk(gain_three_half, 0);
        led_sink_low = 3'b001;
        m.wt(10);
        chk(gain_three_half, 1);
        led_sink_low = 3'b000;
        hardware_enable_reset_pin = 0;
        m.wt(6);
        chk(general_ctrl, 8'h00);
        chk(led_sink_output, 3'h0);
        chk(gain_three_half, 0);
        hardware_enable_reset_pin = 1;
        m.wt(6);
        egc = 8'h00;
        $display("TB: gain and enable test done");
        m.wt(700);
        chk(gap, 7);
        wr3(8'hce, 8'h10, 8'h40, 1);
        m.wt(1000);
        chk(gap, 32 * 10);
        $display("TB: time base test done");
        print_verdict();
    end
endmodule
